/* vui_consts.svh */
// Offsets, field positions and reset values of the vectored interrupt unit
`ifndef VUI_CONSTS_SVH
`define VUI_CONSTS_SVH
`define VUI_OFS_ENA_SET  8'h00
`define VUI_OFS_ENA_CLR  8'h04
`define VUI_OFS_PEND_SET 8'h08
`define VUI_OFS_PEND_CLR 8'h0C
`define VUI_OFS_ACTIVE   8'h10
`define VUI_OFS_TARGET   8'h14
`define VUI_OFS_CTRL     8'h18
`define VUI_OFS_PRIO     8'h40
`define VUI_PRIO_SEL_HI  7
`define VUI_PRIO_SEL_LO  5
`define VUI_PRIO_IDX_HI  4
`define VUI_PRIO_IDX_LO  2
`define VUI_PRIO_BASE    3'h2
`define VUI_PRIO_LANE_W  8
`define VUI_PRIO_KEEP_HI 7
`define VUI_PRIO_KEEP_LO 6
`define VUI_PRIO_LOW_MSK 32'h3F3F_3F3F
`define VUI_CTRL_SQUASH  0
`define VUI_SIZE_WORD    3'h2
`define VUI_RST_WORD     32'h0000_0000
`define VUI_RST_PRIO     2'h0
`endif

/* vui_pkg.sv */
// Types shared by the vectored interrupt unit
package vui_pkg;
  typedef logic [4:0] vui_id_t;
  typedef logic [7:0] vui_prio_t;
  typedef enum logic [1:0] {
    VUI_BUS_IDLE  = 2'b00,
    VUI_BUS_RWAIT = 2'b01
  } vui_bus_e;
  typedef struct packed {
    logic [7:0] addr;
    logic       write;
    logic       ns;
    logic       word;
    logic       valid;
  } vui_dphase_s;
  typedef struct packed {
    logic    enter;
    logic    ret;
    vui_id_t id;
  } vui_core_evt_s;
  typedef struct packed {
    logic      valid;
    vui_id_t   id;
    vui_prio_t prio;
  } vui_take_s;
endpackage : vui_pkg

/* vui_irq_cell.sv */
// Pending and active state of one interrupt
`timescale 1ns/1ps
module vui_irq_cell (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic line,
  input  wire logic level_mode,
  input  wire logic set_pend,
  input  wire logic clr_pend,
  input  wire logic enter,
  input  wire logic ret,
  output logic      pending,
  output logic      active
);
  import vui_pkg::*;
  logic line_prev;
  logic rise;
  logic hw_set;
  logic clr_eff;
  logic next_pending;
  logic next_active;

  // Request sources, edge and level
  assign rise    = line & ~line_prev;                                   // RQ12
  // A level line seen on the entry edge must not re-pend what is being taken
  assign hw_set  = set_pend | (level_mode ? (line & ~active & ~enter) : rise); // RQ15 RQ21 RQ16
  assign clr_eff = clr_pend & ~(level_mode & line);                     // RQ19 RQ20

  // Next state; any set wins over enter, return and clear
  always_comb begin
    next_active  = ret ? 1'b0 : (enter ? 1'b1 : active);                // RQ16 RQ2
    next_pending = pending;
    if (enter) begin
      next_pending = 1'b0;                                              // RQ16
    end
    if (clr_eff) begin
      next_pending = 1'b0;                                              // RQ1
    end
    if (ret && level_mode) begin
      next_pending = line;                                              // RQ17
    end
    if (hw_set) begin
      next_pending = 1'b1;                                              // RQ18
    end
  end

  // State flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_prev <= 1'b0;
      pending   <= 1'b0;
      active    <= 1'b0;
    end else begin
      line_prev <= line;
      pending   <= next_pending;
      active    <= next_active;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  property p_enter_activates;
    @(posedge hclk) disable iff (!hresetn)
    enter && !ret && !set_pend && !(level_mode ? line : (line && !line_prev)) |=> active && !pending;
  endproperty
  a_enter_activates: assert property (p_enter_activates) else $error("enter did not activate"); // RQ16

  property p_clear_keeps_active;
    @(posedge hclk) disable iff (!hresetn)
    clr_pend && !enter && !ret |=> active == $past(active);
  endproperty
  a_clear_keeps_active: assert property (p_clear_keeps_active) else $error("clear changed active"); // RQ2

  property p_level_return;
    @(posedge hclk) disable iff (!hresetn)
    level_mode && ret && !set_pend |=> !active && pending == $past(line);
  endproperty
  a_level_return: assert property (p_level_return) else $error("level return wrong"); // RQ17

  property p_pulse_latch;
    @(posedge hclk) disable iff (!hresetn)
    !level_mode && line && !line_prev |=> pending;
  endproperty
  a_pulse_latch: assert property (p_pulse_latch) else $error("pulse not latched"); // RQ12

  property p_pulse_clear;
    @(posedge hclk) disable iff (!hresetn)
    !level_mode && clr_pend && !set_pend && !(line && !line_prev) |=> !pending;
  endproperty
  a_pulse_clear: assert property (p_pulse_clear) else $error("pulse clear failed"); // RQ20

  property p_level_clear_held;
    @(posedge hclk) disable iff (!hresetn)
    level_mode && clr_pend && line && pending && !enter |=> pending;
  endproperty
  a_level_clear_held: assert property (p_level_clear_held) else $error("level clear dropped"); // RQ19

  property p_pulse_during_handler;
    @(posedge hclk) disable iff (!hresetn)
    !level_mode && active && line && !line_prev && !ret ##1 ret && !clr_pend && !enter |=> pending;
  endproperty
  a_pulse_during_handler: assert property (p_pulse_during_handler) else $error("pulse lost"); // RQ18
endmodule : vui_irq_cell

/* vui_interrupt_state.sv */
// Register banks, interrupt state and selection of the vectored interrupt unit
// How it works
// RQ1 - Clear-pending write of one drops pending; zero ignored; read shows pending.
// RQ2 - Clear-pending write leaves the active state untouched.
// RQ3 - Active-status bits are read-only, one while the interrupt is active.
// RQ4 - Security-target bit zero selects Secure, one selects Non-secure, 32 per word.
// RQ5 - Security-target register reachable only from Secure accesses.
// RQ6 - Non-secure access sees bits of Secure interrupts as zero, writes ignored.
// RQ7 - Eight-bit priority per interrupt, four per word, whole-word access only.
// RQ8 - Only priority bits 7:6 stored; bits 5:0 read zero, writes ignored.
// RQ9 - Lower priority value means more urgent.
// RQ10 - Interrupt M priority in word M/4, byte lane M mod 4.
// RQ11 - Non-secure interrupts get priority adjusted by the squash setting.
// RQ12 - Pulse lines sampled on rising clock; detected pulse latched pending.
// RQ13 - Peripheral holds a pulse high at least one clock cycle.
// RQ14 - Peripheral holds a level request high until serviced.
// RQ15 - Pending on line high while inactive, rising edge, or set-pending.
// RQ16 - Handler entry clears pending and sets active.
// RQ17 - Level return: line high makes pending again, else inactive.
// RQ18 - Pulse during handler gives pending and active, pending on return.
// RQ19 - Level clear-pending ignored while line high, else inactive.
// RQ20 - Pulse clear-pending: pending to inactive, active-pending to active.
// RQ21 - Disabled interrupts still become pending; only taking is blocked.
// RQ22 - Software uses aligned register accesses only.
// RQ23 - Only enabled pending interrupts are offered, by priority.
// RQ24 - Equal priorities resolve to the lowest-numbered interrupt.
`timescale 1ns/1ps
`include "vui_consts.svh"
module vui_interrupt_state #(
  parameter int IRQ_NUM = 32
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  input  wire logic                  hnonsec,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic [IRQ_NUM-1:0]    irq_line,
  input  wire logic [IRQ_NUM-1:0]    irq_level_mode,
  input  wire vui_pkg::vui_core_evt_s core_evt,
  output vui_pkg::vui_take_s         take
);
  import vui_pkg::*;
  localparam int PRIO_WORDS = IRQ_NUM / 4;

  vui_bus_e             bus_state;
  vui_dphase_s          dp;
  logic [IRQ_NUM-1:0]   enable;
  logic [IRQ_NUM-1:0]   target;
  logic [IRQ_NUM-1:0]   pend;
  logic [IRQ_NUM-1:0]   act;
  logic                 squash;
  logic [1:0]           prio_keep [IRQ_NUM];
  vui_prio_t            eff_prio  [IRQ_NUM];
  logic [IRQ_NUM-1:0]   cand;
  logic [IRQ_NUM-1:0]   cand_q;
  logic [IRQ_NUM-1:0]   acc_mask;
  logic [31:0]          acc_mask_w;
  logic [31:0]          rdata_mux;
  logic [31:0]          prio_word;
  logic [31:0]          wdata_m;
  logic                 accept;
  logic                 wr;
  logic                 sel_ena_set;
  logic                 sel_ena_clr;
  logic                 sel_pend_set;
  logic                 sel_pend_clr;
  logic                 sel_target;
  logic                 sel_ctrl;
  logic                 sel_prio;
  logic [2:0]           prio_idx;
  logic                 best_valid;
  vui_id_t              best_id;
  vui_prio_t            best_prio;
  vui_take_s            next_take;

  //////////////////////////////////////////////////////////////////////////////
  // Address phase capture and bus decode
  assign accept       = hsel & htrans[1] & hready;
  assign wr           = dp.valid & dp.write & (bus_state == VUI_BUS_IDLE);
  assign acc_mask     = dp.ns ? target : {IRQ_NUM{1'b1}};                     // RQ6
  assign acc_mask_w   = 32'(acc_mask);
  assign wdata_m      = hwdata & acc_mask_w;
  assign sel_ena_set  = dp.addr == `VUI_OFS_ENA_SET;
  assign sel_ena_clr  = dp.addr == `VUI_OFS_ENA_CLR;
  assign sel_pend_set = dp.addr == `VUI_OFS_PEND_SET;
  assign sel_pend_clr = dp.addr == `VUI_OFS_PEND_CLR;
  assign sel_target   = (dp.addr == `VUI_OFS_TARGET) & ~dp.ns;               // RQ5
  assign sel_ctrl     = dp.addr == `VUI_OFS_CTRL;
  assign sel_prio     = (dp.addr[`VUI_PRIO_SEL_HI:`VUI_PRIO_SEL_LO] == `VUI_PRIO_BASE)
                        & dp.word & ({29'h0, prio_idx} < 32'(PRIO_WORDS));    // RQ7
  assign prio_idx     = dp.addr[`VUI_PRIO_IDX_HI:`VUI_PRIO_IDX_LO];

  // Bus state: writes complete at once, reads take one wait cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state <= VUI_BUS_IDLE;
      dp        <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= `VUI_RST_WORD;
    end else begin
      hresp <= 1'b0;
      if (bus_state == VUI_BUS_RWAIT) begin
        hrdata    <= rdata_mux;
        hreadyout <= 1'b1;
        bus_state <= VUI_BUS_IDLE;
      end else if (accept) begin
        dp        <= '{addr: haddr[7:0], write: hwrite, ns: hnonsec,
                       word: hsize == `VUI_SIZE_WORD, valid: 1'b1};
        hreadyout <= hwrite;
        bus_state <= hwrite ? VUI_BUS_IDLE : VUI_BUS_RWAIT;
      end else begin
        dp.valid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data selection
  always_comb begin
    prio_word = '0;
    for (int b = 0; b < 4; b++) begin
      if (32'(prio_idx) * 4 + b < IRQ_NUM) begin
        prio_word[b*`VUI_PRIO_LANE_W+`VUI_PRIO_KEEP_LO +: 2] = prio_keep[32'(prio_idx)*4+b]; // RQ10 RQ8
      end
    end
    if (sel_ena_set || sel_ena_clr) begin
      rdata_mux = 32'(enable) & acc_mask_w;
    end else if (sel_pend_set || sel_pend_clr) begin
      rdata_mux = 32'(pend) & acc_mask_w;                                     // RQ1
    end else if (dp.addr == `VUI_OFS_ACTIVE) begin
      rdata_mux = 32'(act) & acc_mask_w;                                      // RQ3
    end else if (sel_target) begin
      rdata_mux = 32'(target);                                                // RQ4
    end else if (sel_ctrl) begin
      rdata_mux = {31'h0, squash};
    end else if (sel_prio) begin
      rdata_mux = prio_word & {{8{acc_mask[(32'(prio_idx)*4+3)%IRQ_NUM]}},
                               {8{acc_mask[(32'(prio_idx)*4+2)%IRQ_NUM]}},
                               {8{acc_mask[(32'(prio_idx)*4+1)%IRQ_NUM]}},
                               {8{acc_mask[32'(prio_idx)*4]}}};              // RQ6
    end else begin
      rdata_mux = '0;
    end
  end

  // Squash control, written from Secure only; readable from both
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      squash <= 1'b0;
    end else if (wr && sel_ctrl && !dp.ns) begin
      squash <= hwdata[`VUI_CTRL_SQUASH];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-interrupt enable, target, priority and state
  for (genvar i = 0; i < IRQ_NUM; i++) begin : g_irq
    localparam int LANE = (i % 4) * `VUI_PRIO_LANE_W;
    logic ent;
    logic rtn;
    assign ent = core_evt.enter & (core_evt.id == vui_id_t'(i));
    assign rtn = core_evt.ret & (core_evt.id == vui_id_t'(i));

    // Enable, target and stored priority bits
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        enable[i]    <= 1'b0;
        target[i]    <= 1'b0;
        prio_keep[i] <= `VUI_RST_PRIO;
      end else if (wr) begin
        if (sel_ena_set && wdata_m[i]) begin
          enable[i] <= 1'b1;
        end else if (sel_ena_clr && wdata_m[i]) begin
          enable[i] <= 1'b0;
        end
        if (sel_target) begin
          target[i] <= hwdata[i];                                             // RQ4 RQ5
        end
        if (sel_prio && (32'(prio_idx) == i / 4) && acc_mask[i]) begin
          prio_keep[i] <= hwdata[LANE+`VUI_PRIO_KEEP_HI -: 2];                // RQ8 RQ10
        end
      end
    end

    vui_irq_cell u_cell (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .line       (irq_line[i]),
      .level_mode (irq_level_mode[i]),
      .set_pend   (wr & sel_pend_set & wdata_m[i]),                           // RQ15
      .clr_pend   (wr & sel_pend_clr & wdata_m[i]),                           // RQ1
      .enter      (ent),
      .ret        (rtn),
      .pending    (pend[i]),
      .active     (act[i])
    );

    // Effective priority and eligibility
    assign eff_prio[i] = (squash && target[i]) ? {1'b1, prio_keep[i], 5'h0}
                                               : {prio_keep[i], 6'h0};        // RQ11
    assign cand[i]     = pend[i] & enable[i] & ~act[i];                       // RQ21 RQ23
  end

  //////////////////////////////////////////////////////////////////////////////
  // Selection of the most urgent candidate
  always_comb begin
    best_valid = 1'b0;
    best_id    = '0;
    best_prio  = '1;
    for (int j = IRQ_NUM - 1; j >= 0; j--) begin
      if (cand[j] && (!best_valid || eff_prio[j] <= best_prio)) begin       // RQ9 RQ24
        best_valid = 1'b1;
        best_id    = vui_id_t'(j);
        best_prio  = eff_prio[j];
      end
    end
    next_take = '{valid: best_valid, id: best_id, prio: best_prio};
  end

  // Offer to the core
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      take   <= '0;
      cand_q <= '0;
    end else begin
      take   <= next_take;
      cand_q <= cand;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  property p_take_enabled;
    @(posedge hclk) disable iff (!hresetn)
    take.valid |-> cand_q[take.id] && ((($past(enable) >> take.id) & IRQ_NUM'(1)) != '0);
  endproperty
  a_take_enabled: assert property (p_take_enabled) else $error("disabled irq offered"); // RQ23

  property p_prio_low_zero;
    @(posedge hclk) disable iff (!hresetn)
    $rose(hreadyout) && !dp.write && sel_prio |-> (hrdata & `VUI_PRIO_LOW_MSK) == 32'h0;
  endproperty
  a_prio_low_zero: assert property (p_prio_low_zero) else $error("priority low bits set"); // RQ8

  property p_target_ns_zero;
    @(posedge hclk) disable iff (!hresetn)
    $rose(hreadyout) && !dp.write && dp.ns && dp.addr == `VUI_OFS_TARGET |-> hrdata == 32'h0;
  endproperty
  a_target_ns_zero: assert property (p_target_ns_zero) else $error("target read from non-secure"); // RQ5

  property p_read_wait;
    @(posedge hclk) disable iff (!hresetn)
    accept && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait broken"); // RQ1

  for (genvar k = 0; k < IRQ_NUM; k++) begin : g_chk
    property p_best_choice;
      @(posedge hclk) disable iff (!hresetn)
      take.valid && cand_q[k] |-> ($past(eff_prio[k]) > take.prio)
                                || ($past(eff_prio[k]) == take.prio && vui_id_t'(k) >= take.id);
    endproperty
    a_best_choice: assert property (p_best_choice) else $error("selection not most urgent"); // RQ9 RQ24
  end
endmodule : vui_interrupt_state

/* vui_periph_core.sv */
// Peripheral request lines and processor core facing the interrupt unit
`timescale 1ns/1ps
module vui_periph_core (
  input  wire logic              hclk,
  output logic      [31:0]       irq_line,
  output vui_pkg::vui_core_evt_s core_evt
);
  import vui_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Idle lines and no core event at start
  initial begin
    irq_line = '0;
    core_evt = '0;
  end

  // Pulse held for one full clock so it cannot slip between edges
  task automatic pulse(input int id);
    @(posedge hclk);
    irq_line[id] <= 1'b1;
    @(posedge hclk);
    irq_line[id] <= 1'b0;
  endtask : pulse

  // Level request driven to v on the next clock and held there until the next call
  task automatic level(input int id, input logic v);
    @(posedge hclk);
    irq_line[id] <= v;
  endtask : level

  // Handler entry or return as a one-cycle event, prompt or late
  task automatic core(input logic ent, input logic [4:0] id, input int dly);
    repeat (dly + 1) @(posedge hclk);
    core_evt <= {ent, ~ent, id};
    @(posedge hclk);
    core_evt <= '0;
  endtask : core
endmodule : vui_periph_core

/* tb.sv */
// Self-checking bench of the interrupt state block
`timescale 1ns/1ps
`include "vui_consts.svh"
module tb;
  import vui_pkg::*;
  localparam logic [31:0] KEEP = ~`VUI_PRIO_LOW_MSK;
  logic          hclk;
  logic          hresetn;
  logic          hsel;
  logic [31:0]   haddr;
  logic [1:0]    htrans;
  logic          hwrite;
  logic [2:0]    hsize;
  logic [31:0]   hwdata;
  logic          hnonsec;
  logic [31:0]   hrdata;
  logic          hreadyout;
  logic          hresp;
  logic [31:0]   irq_line;
  logic [31:0]   irq_level_mode;
  vui_core_evt_s core_evt;
  vui_take_s     take;
  logic [31:0]   rq[$];
  logic [13:0]   tq[$];
  logic [31:0]   pw[8];
  logic [7:0]    zr[10];
  logic          ns;
  logic          rd_ph;
  integer        seed;
  int            error_cnt;
  int            n_tests;
  event          take_ev;

  vui_interrupt_state #(.IRQ_NUM(32)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hnonsec(hnonsec),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq_line(irq_line),
    .irq_level_mode(irq_level_mode), .core_evt(core_evt), .take(take)
  );
  vui_periph_core u_part (.hclk(hclk), .irq_line(irq_line), .core_evt(core_evt));

  ////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Comparison and verdict
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // Single transfer of size sz, each phase held until hready is seen high
  task automatic bus(input logic wr, input logic [2:0] sz, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    @(posedge hclk);
    hsel    <= 1'b1;
    htrans  <= 2'b10;
    haddr   <= {24'h0, a};
    hwrite  <= wr;
    hsize   <= sz;
    hnonsec <= ns;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel    <= 1'b0;
    htrans  <= 2'b00;
    hwdata  <= d;
    if (!wr) rq.push_back(e);
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, `VUI_SIZE_WORD, a, d, 32'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, `VUI_SIZE_WORD, a, 32'h0, e);
  endtask : rd

  // Expected offer noted after the two-edge update, sampled off the edge
  task automatic chk_take(input logic v, input logic [4:0] id, input logic [7:0] p);
    repeat (4) @(posedge hclk);
    @(negedge hclk);
    tq.push_back({v, id, p});
    -> take_ev;
  endtask : chk_take
  function automatic logic [7:0] pr(input int id);
    return pw[id / 4][(id % 4) * 8 +: 8] & 8'hC0;
  endfunction : pr
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  // Read data checked when its data phase completes
  always @(posedge hclk) begin
    if (rd_ph && hreadyout === 1'b1) begin
      rd_ph = 1'b0;
      cmp(hrdata, rq.pop_front(), "read data");
      cmp({31'h0, hresp}, 32'h0, "response");
    end
    if (hsel && htrans[1] && hreadyout && !hwrite)
      rd_ph = 1'b1;
  end

  // Offer checked against the oldest note; id and priority only when valid
  initial begin : mon_take
    logic [13:0] te;
    forever begin
      @(take_ev);
      te = tq.pop_front();
      cmp({18'h0, take.valid, te[13] ? take[12:0] : 13'h0}, {18'h0, te}, "take");
    end
  end

  // Hang guard
  initial begin
    #200000;
    error_cnt++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    end_sim();
  end

  // Main sequence
  initial begin
    seed = 42;
    error_cnt = 0;
    n_tests = 0;
    rd_ph = 1'b0;
    ns = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = `VUI_SIZE_WORD;
    hwdata = '0;
    hnonsec = 1'b0;
    irq_level_mode = 32'h0000_1000;
    zr = '{`VUI_OFS_ENA_SET, `VUI_OFS_ENA_CLR, `VUI_OFS_PEND_SET, `VUI_OFS_PEND_CLR, `VUI_OFS_ACTIVE,
           `VUI_OFS_TARGET, `VUI_OFS_CTRL, `VUI_OFS_PRIO, 8'h5C, 8'h30};
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (zr[i]) rd(zr[i], 32'h0);
    wr(`VUI_OFS_ACTIVE, 32'hFFFF_FFFF);
    rd(`VUI_OFS_ACTIVE, 32'h0);
    done("reset");
    for (int n = 0; n < 8; n++) begin
      pw[n] = $random(seed);
      wr(8'(`VUI_OFS_PRIO + 4 * n), pw[n]);
      rd(8'(`VUI_OFS_PRIO + 4 * n), pw[n] & KEEP);
    end
    bus(1'b1, 3'h0, `VUI_OFS_PRIO, 32'hFFFF_FFFF, 32'h0);
    rd(`VUI_OFS_PRIO, pw[0] & KEEP);
    done("priority");
    wr(`VUI_OFS_TARGET, 32'hFFFF_0000);
    ns = 1'b1;
    rd(`VUI_OFS_TARGET, 32'h0);
    wr(`VUI_OFS_TARGET, 32'h0);
    rd(`VUI_OFS_PRIO + 8'h10, pw[4] & KEEP);
    rd(`VUI_OFS_PRIO, 32'h0);
    wr(`VUI_OFS_PRIO, 32'hFFFF_FFFF);
    ns = 1'b0;
    rd(`VUI_OFS_TARGET, 32'hFFFF_0000);
    rd(`VUI_OFS_PRIO, pw[0] & KEEP);
    done("security");
    u_part.pulse(3);
    rd(`VUI_OFS_PEND_CLR, 32'h0000_0008);
    chk_take(1'b0, 5'd0, 8'h00);
    wr(`VUI_OFS_PEND_CLR, 32'h0);
    rd(`VUI_OFS_PEND_SET, 32'h0000_0008);
    wr(`VUI_OFS_PEND_CLR, 32'h0000_0008);
    rd(`VUI_OFS_PEND_CLR, 32'h0);
    wr(`VUI_OFS_PEND_SET, 32'h0010_0020);
    ns = 1'b1;
    rd(`VUI_OFS_PEND_CLR, 32'h0010_0000);
    wr(`VUI_OFS_PEND_CLR, 32'h0010_0020);
    ns = 1'b0;
    rd(`VUI_OFS_PEND_CLR, 32'h0000_0020);
    wr(`VUI_OFS_PEND_CLR, 32'h0000_0020);
    done("pending");
    pw[1] = 32'h4040_C080;
    pw[4] = 32'h0;
    wr(`VUI_OFS_PRIO + 8'h04, pw[1]);
    wr(`VUI_OFS_PRIO + 8'h10, pw[4]);
    wr(`VUI_OFS_ENA_SET, 32'h0001_00F0);
    wr(`VUI_OFS_PEND_SET, 32'h0000_0030);
    chk_take(1'b1, 5'd4, 8'h80);
    wr(`VUI_OFS_PEND_SET, 32'h0001_00C0);
    chk_take(1'b1, 5'd16, 8'h00);
    wr(`VUI_OFS_CTRL, 32'h1);
    chk_take(1'b1, 5'd6, 8'h40);
    wr(`VUI_OFS_PEND_CLR, 32'h0000_00F0);
    chk_take(1'b1, 5'd16, 8'h80);
    wr(`VUI_OFS_PEND_CLR, 32'h0001_0000);
    wr(`VUI_OFS_CTRL, 32'h0);
    wr(`VUI_OFS_ENA_CLR, 32'hFFFF_FFFF);
    done("arbitration");
    wr(`VUI_OFS_ENA_SET, 32'h0000_1100);
    u_part.pulse(8);
    chk_take(1'b1, 5'd8, pr(8));
    u_part.core(1'b1, 5'd8, 0);
    rd(`VUI_OFS_ACTIVE, 32'h0000_0100);
    rd(`VUI_OFS_PEND_CLR, 32'h0);
    u_part.pulse(8);
    rd(`VUI_OFS_PEND_CLR, 32'h0000_0100);
    wr(`VUI_OFS_PEND_CLR, 32'h0000_0100);
    rd(`VUI_OFS_ACTIVE, 32'h0000_0100);
    rd(`VUI_OFS_PEND_CLR, 32'h0);
    u_part.pulse(8);
    u_part.core(1'b0, 5'd8, 3);
    rd(`VUI_OFS_PEND_CLR, 32'h0000_0100);
    rd(`VUI_OFS_ACTIVE, 32'h0);
    u_part.core(1'b1, 5'd8, 0);
    u_part.core(1'b0, 5'd8, 2);
    rd(`VUI_OFS_PEND_CLR, 32'h0);
    rd(`VUI_OFS_ACTIVE, 32'h0);
    done("pulse");
    u_part.level(12, 1'b1);
    rd(`VUI_OFS_PEND_CLR, 32'h0000_1000);
    wr(`VUI_OFS_PEND_CLR, 32'h0000_1000);
    rd(`VUI_OFS_PEND_CLR, 32'h0000_1000);
    u_part.core(1'b1, 5'd12, 1);
    rd(`VUI_OFS_ACTIVE, 32'h0000_1000);
    rd(`VUI_OFS_PEND_CLR, 32'h0);
    u_part.core(1'b0, 5'd12, 0);
    rd(`VUI_OFS_PEND_CLR, 32'h0000_1000);
    rd(`VUI_OFS_ACTIVE, 32'h0);
    u_part.level(12, 1'b0);
    wr(`VUI_OFS_PEND_CLR, 32'h0000_1000);
    rd(`VUI_OFS_PEND_CLR, 32'h0);
    u_part.level(12, 1'b1);
    u_part.core(1'b1, 5'd12, 2);
    u_part.level(12, 1'b0);
    u_part.core(1'b0, 5'd12, 0);
    rd(`VUI_OFS_PEND_CLR, 32'h0);
    rd(`VUI_OFS_ACTIVE, 32'h0);
    done("level");
    repeat (4) @(posedge hclk);
    end_sim();
  end
endmodule : tb
